// File: core/agp_cap_link_if.sv
/*
 * Carrier between the register bank and its two helpers.
 * Assumes one clock domain; all signals are plain levels.
 */
`timescale 1ns/1ps
`default_nettype none

interface agp_cap_link_if;
	logic [2:0] depth_select;
	logic [7:0] depth_field;
	logic       depth_valid;
	logic [2:0] rate_select;
	logic       fast_write_enable;
	logic [2:0] ad_rate;
	logic [2:0] sba_rate;
	logic [2:0] fw_rate;
	logic       rate_valid;

	modport bank (
		output depth_select,
		input  depth_field,
		input  depth_valid,
		output rate_select,
		output fast_write_enable,
		input  ad_rate,
		input  sba_rate,
		input  fw_rate,
		input  rate_valid
	);

	modport depth_map (
		input  depth_select,
		output depth_field,
		output depth_valid
	);

	modport rate_fan (
		input  rate_select,
		input  fast_write_enable,
		output ad_rate,
		output sba_rate,
		output fw_rate,
		output rate_valid
	);
endinterface

`default_nettype wire

// File: core/agp_cap_pkg.sv
/*
 * Constants for the AGP capability and port status registers:
 * offsets, field positions, fixed codes, reset images and states.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package agp_cap_pkg;

	// ----------------------------------------------------------------
	// Register offsets in configuration space
	// ----------------------------------------------------------------
	localparam logic [7:0]  CAP_IDENTIFIER_OFFSET = 8'ha0;
	localparam logic [7:0]  PORT_STATUS_OFFSET    = 8'ha4;

	// ----------------------------------------------------------------
	// Capability identifier fields
	// ----------------------------------------------------------------
	localparam int          MAJOR_REV_LSB   = 20;
	localparam int          MINOR_REV_LSB   = 16;
	localparam int          NEXT_PTR_LSB    = 8;
	localparam int          CAP_ID_LSB      = 0;
	localparam logic [3:0]  MAJOR_REV_VALUE = 4'h2;
	localparam logic [3:0]  MINOR_REV_VALUE = 4'h0;
	localparam logic [7:0]  NEXT_PTR_VALUE  = 8'h00;
	localparam logic [7:0]  CAP_ID_VALUE    = 8'h02;

	// ----------------------------------------------------------------
	// Port capability status fields
	// ----------------------------------------------------------------
	localparam int          DEPTH_LSB           = 24;
	localparam int          DEPTH_LOW_WIDTH     = 6;
	localparam int          SIDEBAND_BIT        = 9;
	localparam int          LARGE_ADDRESS_BIT   = 5;
	localparam int          FAST_WRITE_BIT      = 4;
	localparam int          RATE_LSB            = 0;
	localparam logic [7:0]  DEPTH_RESET         = 8'h1f;
	localparam logic [0:0]  SIDEBAND_VALUE      = 1'h1;
	localparam logic [0:0]  LARGE_ADDRESS_VALUE = 1'h0;
	localparam logic [0:0]  FAST_WRITE_VALUE    = 1'h1;
	localparam logic [2:0]  RATE_CAPABILITY     = 3'h7;
	localparam logic [2:0]  RATE_NONE           = 3'h0;

	// ----------------------------------------------------------------
	// Reset images of both registers
	// ----------------------------------------------------------------
	localparam logic [31:0] CAP_IDENTIFIER_RESET = 32'h00200002;
	localparam logic [31:0] PORT_STATUS_RESET    = 32'h1f000217;

	// ----------------------------------------------------------------
	// Request depth selections from the port control register
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DEPTH_SEL_32 = 3'b000,
		DEPTH_SEL_16 = 3'b001,
		DEPTH_SEL_8  = 3'b010,
		DEPTH_SEL_4  = 3'b011,
		DEPTH_SEL_2  = 3'b100,
		DEPTH_SEL_1  = 3'b101
	} depth_sel_t;

	// ----------------------------------------------------------------
	// Configuration access states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CFG_IDLE   = 2'b00,
		CFG_ANSWER = 2'b01
	} cfg_state_t;

endpackage

`default_nettype wire

// File: core/agp_capability_status_regs.sv
/*
 * Read-only AGP capability identifier and port capability status
 * registers, answered over a simple configuration access port.
 * Assumes the request depth and rate selections come from control
 * registers on the same clock, and that a requester holds nothing
 * after its request is taken.
 */
// Operation
// RULE1 - Major revision field reads constant 0010, revision 2.x.
// RULE2 - Minor revision field reads zero, giving revision 2.0.
// RULE3 - Next capability pointer reads zero, ending the list.
// RULE4 - Low byte reads capability ID 02h for AGP registers.
// RULE5 - Depth field mirrors programmed depth, upper bits zero, reset 1Fh.
// RULE6 - Reported depth is only 32, 16, 8, 4, 2 or 1.
// RULE7 - Sideband addressing bit always reads one.
// RULE8 - Large address bit always reads zero.
// RULE9 - Fast write bit always reads one.
// RULE10 - Rate field reports 1x, 2x and 4x supported after reset.
// RULE11 - Selected rate applies to data bus, sideband and fast writes.
// RULE12 - Writes ignored; reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none

module agp_capability_status_regs
	import agp_cap_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        cfg_req,
	input  wire logic        cfg_write,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	output logic             cfg_ack,
	output logic [31:0]      cfg_rdata,
	input  wire logic [2:0]  depth_select,
	input  wire logic [2:0]  rate_select,
	input  wire logic        fast_write_enable,
	output logic [2:0]       ad_rate,
	output logic [2:0]       sba_rate,
	output logic [2:0]       fw_rate,
	output logic             depth_select_invalid,
	output logic             rate_select_invalid
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	agp_cap_link_if link ();

	request_depth_map u_depth_map (
		.link (link.depth_map)
	);

	transfer_rate_fanout u_rate_fanout (
		.link (link.rate_fan)
	);

	assign link.depth_select      = depth_select;
	assign link.rate_select       = rate_select;
	assign link.fast_write_enable = fast_write_enable;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cfg_state_t  state_r;
	cfg_state_t  state_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [7:0]  depth_r;
	logic [7:0]  depth_nxt;
	logic        depth_bad_r;
	logic        depth_bad_nxt;
	logic [2:0]  ad_rate_r;
	logic [2:0]  ad_rate_nxt;
	logic [2:0]  sba_rate_r;
	logic [2:0]  sba_rate_nxt;
	logic [2:0]  fw_rate_r;
	logic [2:0]  fw_rate_nxt;
	logic        rate_bad_r;
	logic        rate_bad_nxt;

	logic [31:0] cap_identifier_image;
	logic [31:0] port_status_image;
	logic [31:0] selected_word;
	logic [31:0] byte_mask;

	// ----------------------------------------------------------------
	// Request depth tracking
	// ----------------------------------------------------------------
	// Unused selection codes hold the last good depth, so a stray
	// code never shows a depth outside the discrete set.
	always_comb begin
		depth_nxt     = depth_r;
		depth_bad_nxt = ~link.depth_valid;
		if (link.depth_valid) begin
			depth_nxt = link.depth_field; // [RULE5] [RULE6]
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			depth_r     <= DEPTH_RESET; // [RULE5]
			depth_bad_r <= 1'b0;
		end else begin
			depth_r     <= depth_nxt;
			depth_bad_r <= depth_bad_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Transfer rate outputs
	// ----------------------------------------------------------------
	// An unsupported selection keeps the previous data bus and sideband
	// rates, and the fast write rate unless fast writes are disabled,
	// in which case it drops to none, rather than driving a mix of modes.
	always_comb begin
		ad_rate_nxt  = ad_rate_r;
		sba_rate_nxt = sba_rate_r;
		fw_rate_nxt  = fw_rate_r;
		rate_bad_nxt = ~link.rate_valid;
		if (link.rate_valid) begin
			ad_rate_nxt  = link.ad_rate;  // [RULE11]
			sba_rate_nxt = link.sba_rate; // [RULE11]
			fw_rate_nxt  = link.fw_rate;  // [RULE11]
		end else if (!fast_write_enable) begin
			fw_rate_nxt = RATE_NONE;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ad_rate_r  <= RATE_NONE;
			sba_rate_r <= RATE_NONE;
			fw_rate_r  <= RATE_NONE;
			rate_bad_r <= 1'b0;
		end else begin
			ad_rate_r  <= ad_rate_nxt;
			sba_rate_r <= sba_rate_nxt;
			fw_rate_r  <= fw_rate_nxt;
			rate_bad_r <= rate_bad_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register images
	// ----------------------------------------------------------------
	always_comb begin
		cap_identifier_image = 32'h0; // [RULE12]
		cap_identifier_image[MAJOR_REV_LSB +: 4] = MAJOR_REV_VALUE; // [RULE1]
		cap_identifier_image[MINOR_REV_LSB +: 4] = MINOR_REV_VALUE; // [RULE2]
		cap_identifier_image[NEXT_PTR_LSB +: 8]  = NEXT_PTR_VALUE;  // [RULE3]
		cap_identifier_image[CAP_ID_LSB +: 8]    = CAP_ID_VALUE;    // [RULE4]
	end

	always_comb begin
		port_status_image = 32'h0; // [RULE12]
		// Upper two bits of the depth byte stay zero
		port_status_image[DEPTH_LSB +: DEPTH_LOW_WIDTH] =
			depth_r[DEPTH_LOW_WIDTH-1:0]; // [RULE5]
		port_status_image[SIDEBAND_BIT]      = SIDEBAND_VALUE[0];      // [RULE7]
		port_status_image[LARGE_ADDRESS_BIT] = LARGE_ADDRESS_VALUE[0]; // [RULE8]
		port_status_image[FAST_WRITE_BIT]    = FAST_WRITE_VALUE[0];    // [RULE9]
		port_status_image[RATE_LSB +: 3]     = RATE_CAPABILITY;        // [RULE10]
	end

	// ----------------------------------------------------------------
	// Address decode and byte lanes
	// ----------------------------------------------------------------
	always_comb begin
		if (cfg_addr == CAP_IDENTIFIER_OFFSET) begin
			selected_word = cap_identifier_image;
		end else if (cfg_addr == PORT_STATUS_OFFSET) begin
			selected_word = port_status_image;
		end else begin
			// Unmapped dwords read zero
			selected_word = 32'h0;
		end
	end

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign byte_mask[lane*8 +: 8] = {8{cfg_be[lane]}};
		end
	endgenerate

	// ----------------------------------------------------------------
	// Configuration access sequencer
	// ----------------------------------------------------------------
	// One answer per request; a request seen while answering is
	// dropped, so requesters must wait for the acknowledge.
	always_comb begin
		state_nxt = state_r;
		rdata_nxt = rdata_r;
		case (state_r)
			CFG_IDLE: begin
				if (cfg_req) begin
					state_nxt = CFG_ANSWER;
					if (cfg_write) begin
						// Both registers are read only
						rdata_nxt = 32'h0; // [RULE12]
					end else begin
						rdata_nxt = selected_word & byte_mask;
					end
				end
			end
			CFG_ANSWER: begin
				state_nxt = CFG_IDLE;
			end
			default: begin
				state_nxt = CFG_IDLE;
				rdata_nxt = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_r <= CFG_IDLE;
			rdata_r <= 32'h0;
		end else begin
			state_r <= state_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign cfg_ack              = (state_r == CFG_ANSWER);
	assign cfg_rdata            = rdata_r;
	assign ad_rate              = ad_rate_r;
	assign sba_rate             = sba_rate_r;
	assign fw_rate              = fw_rate_r;
	assign depth_select_invalid = depth_bad_r;
	assign rate_select_invalid  = rate_bad_r;

endmodule

`default_nettype wire

// File: core/request_depth_map.sv
/*
 * Maps the request depth selection to the status field value
 * (depth minus one). Purely combinational.
 * Assumes the selection comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module request_depth_map
	import agp_cap_pkg::*;
(
	agp_cap_link_if.depth_map link
);

	// ----------------------------------------------------------------
	// Discrete depths only
	// ----------------------------------------------------------------
	always_comb begin
		link.depth_valid = 1'b1;
		case (link.depth_select)
			DEPTH_SEL_32: link.depth_field = 8'h1f; // [RULE6]
			DEPTH_SEL_16: link.depth_field = 8'h0f; // [RULE6]
			DEPTH_SEL_8:  link.depth_field = 8'h07; // [RULE6]
			DEPTH_SEL_4:  link.depth_field = 8'h03; // [RULE6]
			DEPTH_SEL_2:  link.depth_field = 8'h01; // [RULE6]
			DEPTH_SEL_1:  link.depth_field = 8'h00; // [RULE6]
			default: begin
				// Unused codes: caller keeps its last depth
				link.depth_field = DEPTH_RESET;
				link.depth_valid = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

// File: core/transfer_rate_fanout.sv
/*
 * Applies one selected transfer rate to the data bus, the sideband
 * bus and, when enabled, to fast writes. Purely combinational.
 * Assumes the selection is one-hot over 1x, 2x and 4x.
 */
`timescale 1ns/1ps
`default_nettype none

module transfer_rate_fanout
	import agp_cap_pkg::*;
(
	agp_cap_link_if.rate_fan link
);

	logic one_hot;
	logic supported;

	// ----------------------------------------------------------------
	// Same rate on every enabled path
	// ----------------------------------------------------------------
	always_comb begin
		one_hot   = (link.rate_select == 3'h1) ||
		            (link.rate_select == 3'h2) ||
		            (link.rate_select == 3'h4);
		supported = (link.rate_select & ~RATE_CAPABILITY) == 3'h0;
		link.rate_valid = one_hot && supported;
		link.ad_rate    = link.rate_select; // [RULE11]
		link.sba_rate   = link.rate_select; // [RULE11]
		if (link.fast_write_enable) begin
			link.fw_rate = link.rate_select; // [RULE11]
		end else begin
			link.fw_rate = RATE_NONE;
		end
	end

endmodule

`default_nettype wire

// File: dv/agp_cap_regs_chk.sv
/*
 * Assertions on the AGP capability and port status register bank.
 * Assumes it is bound to the top module; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module agp_cap_regs_chk (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        cfg_req,
	input wire logic        cfg_write,
	input wire logic [7:0]  cfg_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic        cfg_ack,
	input wire logic [31:0] cfg_rdata,
	input wire logic [2:0]  depth_select,
	input wire logic [2:0]  rate_select,
	input wire logic        fast_write_enable,
	input wire logic [2:0]  ad_rate,
	input wire logic [2:0]  sba_rate,
	input wire logic [2:0]  fw_rate,
	input wire logic        depth_select_invalid,
	input wire logic        rate_select_invalid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------------------------------
	// Config port
	// ----------------------------------------------------------------
	logic take;
	assign take = cfg_req && !cfg_ack;

	sequence s_rd(a);
		take && !cfg_write && cfg_addr == a && cfg_be == 4'hf;
	endsequence
	sequence s_pulse;
		cfg_ack ##1 !cfg_ack;
	endsequence

	property p_ack_pulse;
		take |=> s_pulse;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack not a one-cycle pulse after take");

	property p_ack_cause;
		cfg_ack |-> $past(take);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without a taken request");

	property p_write;
		take && cfg_write |=> cfg_ack && cfg_rdata == 32'h0;
	endproperty
	a_write: assert property (p_write)
		else $error("write not acked with zero data");

	property p_capid;
		s_rd(8'ha0) |=> cfg_rdata == 32'h00200002;
	endproperty
	a_capid: assert property (p_capid)
		else $error("capability identifier image wrong");

	property p_stat_fixed;
		s_rd(8'ha4) |=> cfg_rdata[23:0] == 24'h000217;
	endproperty
	a_stat_fixed: assert property (p_stat_fixed)
		else $error("status fixed bits wrong");

	property p_rate_cap;
		s_rd(8'ha4) |=> cfg_rdata[2:0] == 3'h7;
	endproperty
	a_rate_cap: assert property (p_rate_cap)
		else $error("rate capability bits wrong");

	// Read data must hold between answers
	property p_rdata_hold;
		!take |=> $stable(cfg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without a taken request");

	property p_depth;
		s_rd(8'ha4) |=> cfg_rdata[31:24] inside
			{8'h1f, 8'h0f, 8'h07, 8'h03, 8'h01, 8'h00};
	endproperty
	a_depth: assert property (p_depth)
		else $error("request depth field out of set");

	// ----------------------------------------------------------------
	// Rate fan-out and selection flags
	// ----------------------------------------------------------------
	property p_rates;
		rate_select inside {3'h1, 3'h2, 3'h4} |=>
			ad_rate == $past(rate_select) &&
			sba_rate == $past(rate_select) &&
			fw_rate == ($past(fast_write_enable) ? $past(rate_select) : 3'h0);
	endproperty
	a_rates: assert property (p_rates)
		else $error("selected rate not applied to all buses");

	property p_depth_flag;
		$past(reset_n) |->
			depth_select_invalid == ($past(depth_select) > 3'h5);
	endproperty
	a_depth_flag: assert property (p_depth_flag)
		else $error("depth invalid flag wrong");

	property p_rate_flag;
		$past(reset_n) |-> rate_select_invalid ==
			!($past(rate_select) inside {3'h1, 3'h2, 3'h4});
	endproperty
	a_rate_flag: assert property (p_rate_flag)
		else $error("rate invalid flag wrong");
endmodule

bind agp_capability_status_regs agp_cap_regs_chk i_chk (
	.clock, .reset_n, .cfg_req, .cfg_write, .cfg_addr, .cfg_be,
	.cfg_ack, .cfg_rdata, .depth_select, .rate_select,
	.fast_write_enable, .ad_rate, .sba_rate, .fw_rate,
	.depth_select_invalid, .rate_select_invalid
);

`default_nettype wire

// File: dv/agp_capability_status_regs_bench.sv
/*
 * Self-checking bench for the AGP capability and status registers.
 * Assumes the checker binds itself; drives inputs on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module agp_capability_status_regs_bench;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [3:0]  be;
		logic [2:0]  d;
		logic [31:0] e;
	} row_t;

	logic        clock, reset_n, cfg_req, cfg_write, cfg_ack;
	logic        fast_write_enable, depth_select_invalid;
	logic        rate_select_invalid;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_rdata;
	logic [2:0]  depth_select, rate_select, ad_rate, sba_rate, fw_rate;
	int          mismatches, n_compared, cycles, n_ack;
	row_t        rows [15];

	agp_capability_status_regs i_dut (
		.clock, .reset_n, .cfg_req, .cfg_write, .cfg_addr, .cfg_be,
		.cfg_ack, .cfg_rdata, .depth_select, .rate_select,
		.fast_write_enable, .ad_rate, .sba_rate, .fw_rate,
		.depth_select_invalid, .rate_select_invalid
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Request held through the edge that samples ack, then one idle
	task acc(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] exp);
		cfg_req = 1'b1;
		cfg_write = w;
		cfg_addr = a;
		cfg_be = be;
		@(negedge clock);
		chk({31'h0, cfg_ack}, 32'h1);
		chk(cfg_rdata, exp);
		@(negedge clock);
		cfg_req = 1'b0;
		@(negedge clock);
	endtask

	task complete_run;
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			complete_run;
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rows = '{
			'{1'b0, 8'ha0, 4'hf, 3'h0, 32'h00200002},
			'{1'b0, 8'ha4, 4'hf, 3'h0, 32'h1f000217},
			'{1'b0, 8'ha4, 4'hf, 3'h1, 32'h0f000217},
			'{1'b0, 8'ha4, 4'hf, 3'h2, 32'h07000217},
			'{1'b0, 8'ha4, 4'hf, 3'h3, 32'h03000217},
			'{1'b0, 8'ha4, 4'hf, 3'h4, 32'h01000217},
			'{1'b0, 8'ha4, 4'hf, 3'h5, 32'h00000217},
			'{1'b1, 8'ha4, 4'hf, 3'h5, 32'h0},
			'{1'b1, 8'ha0, 4'hf, 3'h5, 32'h0},
			'{1'b0, 8'ha4, 4'h1, 3'h0, 32'h00000017},
			'{1'b0, 8'ha4, 4'h8, 3'h0, 32'h1f000000},
			'{1'b0, 8'ha0, 4'h6, 3'h0, 32'h00200000},
			'{1'b0, 8'ha8, 4'hf, 3'h0, 32'h0},
			'{1'b0, 8'h9c, 4'hf, 3'h2, 32'h0},
			'{1'b0, 8'ha4, 4'hf, 3'h2, 32'h07000217}};
		{reset_n, cfg_req, cfg_write, fast_write_enable} = 4'h0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		depth_select = 3'h0;
		rate_select = 3'h1;
		{mismatches, n_compared} = '0;
		repeat (20) @(negedge clock);
		chk({20'h0, cfg_ack, depth_select_invalid, rate_select_invalid,
			ad_rate, sba_rate, fw_rate}, 32'h0);
		chk(cfg_rdata, 32'h0);
		reset_n = 1'b1;
		acc(1'b0, 8'ha4, 4'hf, 32'h1f000217);
		foreach (rows[i]) begin
			depth_select = rows[i].d;
			repeat (2) @(negedge clock);
			acc(rows[i].w,
				rows[i].a,
				rows[i].be,
				rows[i].e);
		end
		for (int i = 0; i < 6; i++) begin
			rate_select = 3'h1 << (i % 3);
			fast_write_enable = (i > 2);
			@(negedge clock);
			chk({23'h0, ad_rate, sba_rate, fw_rate},
				{23'h0, rate_select, rate_select,
				fast_write_enable ? rate_select : 3'h0});
		end
		// Bad rate holds the last good one; fast writes off gives none
		rate_select = 3'h3;
		fast_write_enable = 1'b0;
		@(negedge clock);
		chk({22'h0, rate_select_invalid, ad_rate, sba_rate,
			fw_rate}, {22'h0, 1'b1, 9'h120});
		depth_select = 3'h7;
		repeat (2) @(negedge clock);
		chk({31'h0, depth_select_invalid}, 32'h1);
		acc(1'b0, 8'ha4, 4'hf, 32'h07000217);
		// Request held high: ack cycle swallows the repeat
		depth_select = 3'h0;
		rate_select = 3'h1;
		n_ack = 0;
		cfg_req = 1'b1;
		cfg_write = 1'b0;
		cfg_addr = 8'ha0;
		repeat (4) begin
			@(negedge clock);
			n_ack += cfg_ack;
		end
		cfg_req = 1'b0;
		chk(n_ack, 32'h2);
		complete_run;
	end
endmodule

`default_nettype wire
